// file: design/i2csr_params.svh
// constants for the two-wire slave register access port
// Notes on behaviour
// - the port is only a slave; the master makes the clock, START and STOP.
// - the clock line is never held low; every answer is ready in time.
// - the pointer advances by one after every data byte, valid or not.
// - an invalid register address is not acknowledged; the transfer still goes on.
// - reading an invalid location sends all zero bits, then the pointer advances.
// - sequential reads run over the whole range and wrap past the top.
// - data written to an invalid location is not acknowledged; valid ones are.
// - page writes run over the whole range and wrap past the top.
// - data falling while the clock is high is a START.
// - data rising while the clock is high is a STOP.
// - data changes only while the clock is low; high-phase changes are conditions.
// - one clock pulse carries exactly one bit.
// - bytes are eight bits, answered by an acknowledge in a ninth slot.
// - for START and STOP the sampled data line is delayed about 300 ns.
// - slave address is 40h with the strap low and 41h with it high.
// - bytes aimed at an invalid location are dropped; registers stay unchanged.
// - a read without a pointer write starts at the pointer as left.
// - every byte moves most significant bit first.
`ifndef I2CSR_PARAMS_SVH
`define I2CSR_PARAMS_SVH

`define I2CSR_ADDR_STRAP_LO 7'h40
`define I2CSR_ADDR_STRAP_HI 7'h41
`define I2CSR_CLK_PERIOD_NS 10
`define I2CSR_SDA_HOLD_NS   300
`define I2CSR_SDA_HOLD_CYC  ((`I2CSR_SDA_HOLD_NS + `I2CSR_CLK_PERIOD_NS - 1) / `I2CSR_CLK_PERIOD_NS)
`define I2CSR_SCL_CNT_W     6
`define I2CSR_REG_PAGE      4'h1
`define I2CSR_REG_IDX_W     4
`define I2CSR_REG_RESET     8'h00
`define I2CSR_PTR_RESET     8'h00
`define I2CSR_TX_INVALID    8'h00
`define I2CSR_PIN_IDLE      3'h7

`endif

// file: design/i2csr_pkg.sv
// types shared by the two-wire slave register access port
package i2csr_pkg;

  typedef enum logic [2:0] {
    I2CSR_IDLE     = 3'h0,
    I2CSR_ADDR     = 3'h1,
    I2CSR_ADDR_ACK = 3'h3,
    I2CSR_RX       = 3'h2,
    I2CSR_RX_ACK   = 3'h6,
    I2CSR_TX       = 3'h7,
    I2CSR_TX_ACK   = 3'h5
  } i2csr_state_e;

  typedef logic [7:0] i2csr_byte_t;

endpackage : i2csr_pkg

// file: design/i2csr_sync.sv
// two-flop synchroniser for pins that arrive from outside the clock domain
module i2csr_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_in,    // sampling clock
  input  wire logic         rst_n_in,  // async reset, active low
  input  wire logic [W-1:0] d_in,      // asynchronous inputs
  output logic      [W-1:0] q_out      // synchronised copy
);

  logic [W-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta  <= RST_VAL;
      q_out <= RST_VAL;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule : i2csr_sync

// file: design/i2csr_regmem.sv
// register space behind the serial port, registered read data
`include "i2csr_params.svh"
module i2csr_regmem #(
  parameter int IDX_W = 4,
  parameter int DW    = 8
) (
  input  wire logic             clk_in,      // system clock
  input  wire logic             rst_n_in,    // async reset, active low
  input  wire logic             wr_en_in,    // write strobe
  input  wire logic [IDX_W-1:0] wr_idx_in,   // write index
  input  wire logic [DW-1:0]    wr_data_in,  // write data
  input  wire logic [IDX_W-1:0] rd_idx_in,   // read index
  output logic      [DW-1:0]    rd_data_out  // read data, one cycle late
);

  logic [DW-1:0] mem [2**IDX_W];

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < 2**IDX_W; i++)
      begin
        mem[i] <= `I2CSR_REG_RESET;
      end
    end
    else if (wr_en_in)
    begin
      mem[wr_idx_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_data_out <= `I2CSR_REG_RESET;
    end
    else
    begin
      rd_data_out <= mem[rd_idx_in];
    end
  end

endmodule : i2csr_regmem

// file: design/i2csr_top.sv
// two-wire slave port giving a bus master access to the register space
`include "i2csr_params.svh"
module i2csr_top (
  input  wire logic              sys_clk_in,    // system clock, 100 MHz
  input  wire logic              reset_n_in,    // async reset, active low
  input  wire logic              scl_in,        // serial clock pin, from master
  input  wire logic              sda_in,        // serial data pin level
  output logic                   sda_out,       // data drive value, always low
  output logic                   sda_oe_n_out,  // low while pulling data low
  input  wire logic              addr_sel_in,   // slave address strap
  output logic                   wr_stb_out,    // one-cycle register write pulse
  output i2csr_pkg::i2csr_byte_t wr_addr_out,   // register written
  output i2csr_pkg::i2csr_byte_t wr_data_out,   // value written
  output i2csr_pkg::i2csr_byte_t ptr_out,       // current register pointer
  output logic                   busy_out       // addressed or listening
);
  import i2csr_pkg::*;

  localparam int HOLD = `I2CSR_SDA_HOLD_CYC;

  // reset release
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // pin synchronisers
  logic [2:0] pins_s;
  wire        scl_s  = pins_s[2];
  wire        sda_s  = pins_s[1];
  wire        strap_s = pins_s[0];

  i2csr_sync #(
    .W       (3),
    .RST_VAL (`I2CSR_PIN_IDLE)
  ) u_sync (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n),
    .d_in     ({scl_in, sda_in, addr_sel_in}),
    .q_out    (pins_s)
  );

  // strap caught once; the synchroniser shows its idle value for two edges
  // after release, so the pin is only taken on the third edge
  logic [1:0] strap_age;
  logic [6:0] own_addr;
  wire  [6:0] strap_addr = strap_s ? `I2CSR_ADDR_STRAP_HI : `I2CSR_ADDR_STRAP_LO;

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_age <= 2'h0;
      own_addr  <= `I2CSR_ADDR_STRAP_LO;
    end
    else if (strap_age != 2'h3)
    begin
      strap_age <= strap_age + 2'h1;
      own_addr  <= (strap_age == 2'h2) ? strap_addr : own_addr;
    end
  end

  // delayed data copy and clock-high age for condition detection
  logic [HOLD-1:0]              sda_line;
  logic                         sda_dly_q;
  logic                         scl_q;
  logic [`I2CSR_SCL_CNT_W-1:0]  scl_hi_cnt;

  wire sda_dly  = sda_line[HOLD-1];
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  // a data edge only counts once the clock has been high longer than the delay,
  // so a late data change after a clock fall is never taken for a condition
  wire scl_hi_ok  = scl_s && (scl_hi_cnt >= `I2CSR_SCL_CNT_W'(HOLD));
  wire start_det  = scl_hi_ok & sda_dly_q & ~sda_dly;
  wire stop_det   = scl_hi_ok & ~sda_dly_q & sda_dly;
  wire cnt_sat    = &scl_hi_cnt;

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_line   <= '1;
      sda_dly_q  <= 1'b1;
      scl_q      <= 1'b1;
      scl_hi_cnt <= '0;
    end
    else
    begin
      sda_line   <= {sda_line[HOLD-2:0], sda_s};
      sda_dly_q  <= sda_dly;
      scl_q      <= scl_s;
      scl_hi_cnt <= !scl_s ? '0 : (cnt_sat ? scl_hi_cnt : scl_hi_cnt + 1'b1);
    end
  end

  // protocol engine state
  i2csr_state_e state;
  i2csr_state_e next_state;
  logic [2:0]   bitcnt;
  logic [2:0]   next_bitcnt;
  i2csr_byte_t  shreg;
  i2csr_byte_t  next_shreg;
  i2csr_byte_t  ptr;
  i2csr_byte_t  next_ptr;
  logic         byte_full;
  logic         next_byte_full;
  logic         rw;
  logic         next_rw;
  logic         first;
  logic         next_first;
  logic         mack;
  logic         next_mack;
  logic         oe_n;
  logic         next_oe_n;
  logic         next_wr_stb;
  i2csr_byte_t  rd_data;

  // decode
  wire         ptr_valid  = (ptr[7:4] == `I2CSR_REG_PAGE);
  wire         rx_valid   = (shreg[7:4] == `I2CSR_REG_PAGE);
  wire         addr_match = (shreg[7:1] == own_addr);
  wire i2csr_byte_t tx_byte = ptr_valid ? rd_data : `I2CSR_TX_INVALID;
  wire i2csr_byte_t shin    = {shreg[6:0], sda_s};
  wire i2csr_byte_t ptr_inc = ptr + 8'h01;

  // the line is only ever pulled low or released; the clock pin is input
  // only, so the master is never held off
  always_comb
  begin
    next_state     = state;
    next_bitcnt    = bitcnt;
    next_shreg     = shreg;
    next_ptr       = ptr;
    next_byte_full = byte_full;
    next_rw        = rw;
    next_first     = first;
    next_mack      = mack;
    next_oe_n      = oe_n;
    next_wr_stb    = 1'b0;
    if (start_det)
    begin
      next_state     = I2CSR_ADDR;
      next_bitcnt    = 3'h0;
      next_byte_full = 1'b0;
      next_oe_n      = 1'b1;
    end
    else if (stop_det)
    begin
      next_state     = I2CSR_IDLE;
      next_byte_full = 1'b0;
      next_oe_n      = 1'b1;
    end
    else
    begin
      case (state)
        I2CSR_ADDR, I2CSR_RX:
        begin
          if (scl_rise)
          begin
            next_shreg  = shin;
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == 3'h7)
            begin
              next_byte_full = 1'b1;
            end
          end
          else if (scl_fall && byte_full)
          begin
            next_byte_full = 1'b0;
            if (state == I2CSR_ADDR)
            begin
              if (addr_match)
              begin
                next_oe_n  = 1'b0;
                next_rw    = shreg[0];
                next_state = I2CSR_ADDR_ACK;
              end
              else
              begin
                next_state = I2CSR_IDLE;
              end
            end
            else if (first)
            begin
              next_first = 1'b0;
              next_ptr   = shreg;
              next_oe_n  = ~rx_valid;
              next_state = I2CSR_RX_ACK;
            end
            else
            begin
              next_wr_stb = ptr_valid;
              next_oe_n   = ~ptr_valid;
              next_ptr    = ptr_inc;
              next_state  = I2CSR_RX_ACK;
            end
          end
        end
        I2CSR_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            next_bitcnt = 3'h0;
            if (rw)
            begin
              next_shreg = tx_byte;
              next_oe_n  = tx_byte[7];
              next_state = I2CSR_TX;
            end
            else
            begin
              next_oe_n  = 1'b1;
              next_first = 1'b1;
              next_state = I2CSR_RX;
            end
          end
        end
        I2CSR_RX_ACK:
        begin
          if (scl_fall)
          begin
            next_oe_n   = 1'b1;
            next_bitcnt = 3'h0;
            next_state  = I2CSR_RX;
          end
        end
        I2CSR_TX:
        begin
          if (scl_rise)
          begin
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == 3'h7)
            begin
              next_byte_full = 1'b1;
            end
          end
          else if (scl_fall)
          begin
            if (byte_full)
            begin
              next_byte_full = 1'b0;
              next_oe_n      = 1'b1;
              next_ptr       = ptr_inc;
              next_state     = I2CSR_TX_ACK;
            end
            else
            begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe_n  = shreg[6];
            end
          end
        end
        I2CSR_TX_ACK:
        begin
          if (scl_rise)
          begin
            next_mack = ~sda_s;
          end
          else if (scl_fall)
          begin
            next_bitcnt = 3'h0;
            if (mack)
            begin
              next_shreg = tx_byte;
              next_oe_n  = tx_byte[7];
              next_state = I2CSR_TX;
            end
            else
            begin
              // not acknowledged: leave the line high for the master's STOP
              next_oe_n  = 1'b1;
              next_state = I2CSR_IDLE;
            end
          end
        end
        default:
        begin
          next_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= I2CSR_IDLE;
      bitcnt    <= 3'h0;
      shreg     <= 8'h00;
      ptr       <= `I2CSR_PTR_RESET;
      byte_full <= 1'b0;
      rw        <= 1'b0;
      first     <= 1'b0;
      mack      <= 1'b0;
      oe_n      <= 1'b1;
    end
    else
    begin
      state     <= next_state;
      bitcnt    <= next_bitcnt;
      shreg     <= next_shreg;
      ptr       <= next_ptr;
      byte_full <= next_byte_full;
      rw        <= next_rw;
      first     <= next_first;
      mack      <= next_mack;
      oe_n      <= next_oe_n;
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_out      <= 1'b0;
      sda_oe_n_out <= 1'b1;
      wr_stb_out   <= 1'b0;
      wr_addr_out  <= 8'h00;
      wr_data_out  <= 8'h00;
      ptr_out      <= `I2CSR_PTR_RESET;
      busy_out     <= 1'b0;
    end
    else
    begin
      sda_out      <= 1'b0;
      sda_oe_n_out <= next_oe_n;
      wr_stb_out   <= next_wr_stb;
      wr_addr_out  <= next_wr_stb ? ptr : wr_addr_out;
      wr_data_out  <= next_wr_stb ? shreg : wr_data_out;
      ptr_out      <= next_ptr;
      busy_out     <= (next_state != I2CSR_IDLE);
    end
  end

  // register space; write lands two cycles after the strobe decision, one after wr_stb_out
  i2csr_regmem #(
    .IDX_W (`I2CSR_REG_IDX_W),
    .DW    (8)
  ) u_regmem (
    .clk_in      (sys_clk_in),
    .rst_n_in    (rst_n),
    .wr_en_in    (wr_stb_out),
    .wr_idx_in   (wr_addr_out[3:0]),
    .wr_data_in  (wr_data_out),
    .rd_idx_in   (ptr[3:0]),
    .rd_data_out (rd_data)
  );

endmodule : i2csr_top

// file: test/i2csr_properties.sv
// concurrent checks on the two-wire slave port
module i2csr_properties (
  input wire logic                   sys_clk_in,   // system clock
  input wire logic                   reset_n_in,   // reset, active low
  input wire logic                   scl_in,       // serial clock pin
  input wire logic                   sda_in,       // data line level
  input wire logic                   sda_out,      // data drive value
  input wire logic                   sda_oe_n_out, // low while pulling
  input wire logic                   addr_sel_in,  // address strap
  input wire logic                   wr_stb_out,   // store pulse
  input wire i2csr_pkg::i2csr_byte_t wr_addr_out,  // stored location
  input wire i2csr_pkg::i2csr_byte_t wr_data_out,  // stored value
  input wire i2csr_pkg::i2csr_byte_t ptr_out,      // register pointer
  input wire logic                   busy_out      // engine active
);
  import i2csr_pkg::*;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  property p_drive_low; sda_out == 1'b0; endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("data drive value not low");
  property p_oe_scl_low; $changed(sda_oe_n_out) |-> !scl_in; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data drive changed while clock high");
  property p_stb_pulse; wr_stb_out |=> !wr_stb_out; endproperty
  a_stb_pulse: assert property (p_stb_pulse)
    else $error("store pulse longer than one cycle");
  property p_stb_valid; wr_stb_out |-> wr_addr_out[7:4] == 4'h1; endproperty
  a_stb_valid: assert property (p_stb_valid)
    else $error("store to invalid location");
  property p_stb_ptr; wr_stb_out |-> ##[0:2] ptr_out == wr_addr_out + 8'h01; endproperty
  a_stb_ptr: assert property (p_stb_ptr)
    else $error("pointer did not advance after store");
  property p_ptr_scl_low; $changed(ptr_out) |-> !scl_in; endproperty
  a_ptr_scl_low: assert property (p_ptr_scl_low)
    else $error("pointer moved while clock high");
  property p_idle_release; !busy_out && $past(!busy_out) |-> sda_oe_n_out; endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("data line pulled while idle");
  property p_idle_ptr; !busy_out |=> $stable(ptr_out); endproperty
  a_idle_ptr: assert property (p_idle_ptr)
    else $error("pointer moved while idle");
  property p_stb_busy; wr_stb_out |-> busy_out && !scl_in; endproperty
  a_stb_busy: assert property (p_stb_busy)
    else $error("store outside a transfer");
endmodule : i2csr_properties

bind i2csr_top i2csr_properties chk_u (.sys_clk_in, .reset_n_in, .scl_in, .sda_in, .sda_out,
  .sda_oe_n_out, .addr_sel_in, .wr_stb_out, .wr_addr_out, .wr_data_out, .ptr_out, .busy_out);

// file: test/i2csr_master.sv
// bus master model driving the serial clock and the data line
module i2csr_master (
  input  wire logic lclk_in,      // link tick, still outside frames
  input  wire logic sda_in,       // resolved data line
  output logic      scl_out,      // serial clock
  output logic      sda_oe_n_out, // low while pulling data low
  output logic      frame_out     // high during a frame
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 14;  // quarter bit; keeps clock low above 1300 ns
  initial
  begin
    scl_out      = 1'b1;
    sda_oe_n_out = 1'b1;
    frame_out    = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge lclk_in);
  endtask : tick
  // entered from idle, or with the clock low for a repeated start
  task automatic start();
    frame_out = 1'b1;
    tick(Q);
    sda_oe_n_out = 1'b1;
    tick(Q);
    scl_out = 1'b1;
    tick(2 * Q);
    sda_oe_n_out = 1'b0;
    tick(2 * Q);
    scl_out = 1'b0;
  endtask : start
  task automatic stop();
    tick(Q);
    sda_oe_n_out = 1'b0;
    tick(Q);
    scl_out = 1'b1;
    tick(2 * Q);
    sda_oe_n_out = 1'b1;
    tick(2 * Q);
    frame_out = 1'b0;
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    tick(Q);
    sda_oe_n_out = b;
    tick(Q);
    scl_out = 1'b1;
    tick(Q);
    r = sda_in;
    tick(Q);
    scl_out = 1'b0;
  endtask : bit_io
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte
  // last byte gets a not-acknowledge so the slave lets go
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : rbyte
endmodule : i2csr_master

// file: test/tb.sv
// self-checking bench for the two-wire slave port
`define CHK(got, exp) \
  begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %0h expected %0h", $time, got, exp); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import i2csr_pkg::*;
  logic        sys_clk     = 1'b0;
  logic        reset_n     = 1'b0;
  logic        addr_sel    = 1'b0;
  logic        lclk_raw    = 1'b0;
  logic        lclk, scl, sda, m_oe_n, frame, sda_drv, sda_oe_n, wr_stb, busy;
  i2csr_byte_t wr_addr, wr_data, ptr;
  int          error_cnt   = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          stores      = 0;
  always #5 sys_clk = ~sys_clk;
  always #24 lclk_raw = ~lclk_raw;
  assign lclk = lclk_raw & frame;
  assign sda  = m_oe_n & sda_oe_n;  // pull-up unless someone pulls low
  i2csr_master master_u (.lclk_in(lclk), .sda_in(sda), .scl_out(scl),
    .sda_oe_n_out(m_oe_n), .frame_out(frame));
  i2csr_top dut_u (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_drv), .sda_oe_n_out(sda_oe_n), .addr_sel_in(addr_sel), .wr_stb_out(wr_stb),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data), .ptr_out(ptr), .busy_out(busy));
  task automatic final_report();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  always @(posedge sys_clk)
  begin
    cycles++;
    if (wr_stb === 1'b1)
      stores++;
    if (cycles == 80000)
    begin
      error_cnt++;
      final_report();
    end
  end
  task automatic do_reset(input logic sel);
    @(posedge sys_clk);
    #1;
    reset_n  = 1'b0;
    addr_sel = sel;
    repeat (20) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    repeat (12) @(posedge sys_clk);
  endtask : do_reset
  task automatic wr(input logic [7:0] d, input logic exp_ack);
    logic a;
    master_u.wbyte(d, a);
    `CHK(a, exp_ack)
  endtask : wr
  task automatic rd(input logic last, input logic [7:0] exp);
    logic [7:0] d;
    master_u.rbyte(last, d);
    `CHK(d, exp)
  endtask : rd
  task automatic t_page_write();
    stores = 0;
    master_u.start();
    wr(8'h80, 1'b1);
    `CHK(busy, 1'b1)
    wr(8'h1e, 1'b1);
    wr(8'ha1, 1'b1);
    wr(8'ha2, 1'b1);
    wr(8'ha3, 1'b0);
    master_u.stop();
    `CHK(busy, 1'b0)
    `CHK(stores, 2)
    `CHK(wr_addr, 8'h1f)
    `CHK(wr_data, 8'ha2)
    `CHK(ptr, 8'h21)
  endtask : t_page_write
  // pointer set in one transfer, read in the next
  task automatic t_read_seq();
    master_u.start();
    wr(8'h80, 1'b1);
    wr(8'h1e, 1'b1);
    master_u.stop();
    master_u.start();
    wr(8'h81, 1'b1);
    rd(1'b0, 8'ha1);
    rd(1'b0, 8'ha2);
    rd(1'b1, 8'h00);
    master_u.stop();
    `CHK(ptr, 8'h21)
  endtask : t_read_seq
  task automatic t_bad_ptr_wrap();
    stores = 0;
    master_u.start();
    wr(8'h80, 1'b1);
    wr(8'hff, 1'b0);
    wr(8'h55, 1'b0);
    wr(8'h66, 1'b0);
    master_u.start();
    wr(8'h81, 1'b1);
    rd(1'b1, 8'h00);
    master_u.stop();
    `CHK(stores, 0)
    `CHK(ptr, 8'h02)
  endtask : t_bad_ptr_wrap
  // second reset in mid-run with the strap high
  task automatic t_strap();
    do_reset(1'b1);
    `CHK(ptr, 8'h00)
    `CHK(sda_oe_n, 1'b1)
    master_u.start();
    wr(8'h80, 1'b0);
    `CHK(busy, 1'b0)
    master_u.start();
    wr(8'h82, 1'b1);
    wr(8'h10, 1'b1);
    master_u.start();
    wr(8'h83, 1'b1);
    rd(1'b1, 8'h00);
    master_u.stop();
    `CHK(ptr, 8'h11)
  endtask : t_strap
  initial
  begin
    do_reset(1'b0);
    t_page_write();
    t_read_seq();
    t_bad_ptr_wrap();
    t_strap();
    final_report();
  end
endmodule : tb
